//--- hdl/bds_pkg.sv
// Shared constants and carrier types for the burst-of-four DDR SRAM command timing block.

package bds_pkg;

   // --------------------------------------------------------------------
   // Sizes
   // --------------------------------------------------------------------
   localparam int BDS_ADDR_W      = 20;
   localparam int BDS_LANE_W      = 9;
   localparam int BDS_LANES       = 2;
   localparam int BDS_DATA_W      = BDS_LANE_W * BDS_LANES;
   localparam int BDS_BURST_LEN   = 4;
   localparam int BDS_BEATS_CYC   = 2;
   localparam int BDS_WBUF_DEPTH  = 32;

   // --------------------------------------------------------------------
   // Address steps and idle data level
   // --------------------------------------------------------------------
   localparam logic [BDS_ADDR_W-1:0] BDS_ADDR_ONE = BDS_ADDR_W'(1);
   localparam logic [BDS_ADDR_W-1:0] BDS_ADDR_TWO = BDS_ADDR_W'(BDS_BEATS_CYC);
   localparam logic [BDS_DATA_W-1:0] BDS_DATA_IDLE = '0;

   // --------------------------------------------------------------------
   // Carrier types
   // --------------------------------------------------------------------
   typedef struct packed {
      logic [BDS_ADDR_W-1:0] addr;
      logic [BDS_DATA_W-1:0] data_rise;
      logic [BDS_DATA_W-1:0] data_fall;
      logic [BDS_LANES-1:0]  mask_rise_n;
      logic [BDS_LANES-1:0]  mask_fall_n;
   } bds_wbeat_s;

   typedef struct packed {
      logic                  rd_last;
      logic                  wr_last;
      logic                  prev_nop;
      logic                  rd_v0;
      logic [BDS_ADDR_W-1:0] rd_a0;
      logic                  rd_v1;
      logic [BDS_ADDR_W-1:0] rd_a1;
      logic                  rd_v2;
      logic [BDS_ADDR_W-1:0] rd_a2;
      logic                  wr_v0;
      logic [BDS_ADDR_W-1:0] wr_a0;
      logic                  wr_v1;
      logic [BDS_ADDR_W-1:0] wr_a1;
      logic [BDS_DATA_W-1:0] q_rise;
      logic [BDS_DATA_W-1:0] q_fall;
      logic                  q_oe;
      logic                  q_valid;
      logic                  wbuf_ready;
   } bds_state_s;

   localparam bds_state_s BDS_STATE_RST = '0;

endpackage

//--- hdl/bds_fifo.sv
// Write beat buffer: a first-in first-out queue with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none

module bds_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = bds_pkg::BDS_WBUF_DEPTH
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);

   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   // Depth must be a power of two so that the pointers wrap by themselves.
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] PTR_ONE   = PW'(1);
   localparam logic [PW:0]   CNT_ONE   = (PW+1)'(1);
   localparam logic [PW:0]   CNT_FULL  = (PW+1)'(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW:0]   count;
   } bds_fifo_state_s;

   bds_fifo_state_s r_reg;
   bds_fifo_state_s r_next;
   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic             push;
   logic             pop;

   assign o_in_ready  = (r_reg.count != CNT_FULL);
   assign o_out_valid = (r_reg.count != '0);
   assign o_out_data  = store[r_reg.rptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // --------------------------------------------------------------------
   // Pointers and fill count
   // --------------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.wptr = r_reg.wptr + PTR_ONE;
      end
      if (pop) begin
         r_next.rptr = r_reg.rptr + PTR_ONE;
      end
      if (push && !pop) begin
         r_next.count = r_reg.count + CNT_ONE;
      end else if (pop && !push) begin
         r_next.count = r_reg.count - CNT_ONE;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         store[r_reg.wptr] <= i_in_data;
      end
   end

endmodule

`default_nettype wire

//--- hdl/bds_sram.sv
// Command sequencing, burst timing and storage of the burst-of-four DDR SRAM.
`timescale 1ns/100ps
`default_nettype none

module bds_sram (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst,
   input  wire logic                          i_clk_run,
   input  wire logic                          i_rd_sel_n,
   input  wire logic                          i_wr_sel_n,
   input  wire logic [bds_pkg::BDS_ADDR_W-1:0] i_addr,
   input  wire logic [bds_pkg::BDS_DATA_W-1:0] i_wr_data_rise,
   input  wire logic [bds_pkg::BDS_DATA_W-1:0] i_wr_data_fall,
   input  wire logic                          i_lane0_write_mask_n_rise,
   input  wire logic                          i_lane1_write_mask_n_rise,
   input  wire logic                          i_lane0_write_mask_n_fall,
   input  wire logic                          i_lane1_write_mask_n_fall,
   output logic [bds_pkg::BDS_DATA_W-1:0]      o_rd_data_rise,
   output logic [bds_pkg::BDS_DATA_W-1:0]      o_rd_data_fall,
   output logic                               o_rd_oe,
   output logic                               o_rd_valid,
   output logic                               o_wbuf_ready
);

   // --------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------
   localparam int AW = bds_pkg::BDS_ADDR_W;
   localparam int DW = bds_pkg::BDS_DATA_W;
   localparam int LW = bds_pkg::BDS_LANE_W;
   localparam int NL = bds_pkg::BDS_LANES;

   bds_pkg::bds_state_s st_reg;
   bds_pkg::bds_state_s st_next;
   bds_pkg::bds_wbeat_s push_entry;
   bds_pkg::bds_wbeat_s wbuf_out;

   logic [DW-1:0] mem [0:(2**AW)-1];
   logic          rd_go;
   logic          wr_req;
   logic          wr_go;
   logic          push_valid;
   logic          fifo_in_ready;
   logic          wbuf_valid;
   logic          wbuf_take;
   logic          wbuf_pop;
   logic [AW-1:0] rd_base;
   logic [DW-1:0] rd_word0;
   logic [DW-1:0] rd_word1;
   logic [AW-1:0] wr_addr_hi;

   // --------------------------------------------------------------------
   // Array read port
   // --------------------------------------------------------------------
   // Burst addresses step linearly from the registered start address.
   assign rd_base  = st_reg.rd_v1 ? st_reg.rd_a1 : st_reg.rd_a2;
   assign rd_word0 = mem[rd_base];
   assign rd_word1 = mem[rd_base + bds_pkg::BDS_ADDR_ONE];

   // --------------------------------------------------------------------
   // Sequencers
   // --------------------------------------------------------------------
   always_comb begin
      st_next    = st_reg;
      rd_go      = 1'b0;
      wr_req     = 1'b0;
      wr_go      = 1'b0;
      push_valid = 1'b0;
      push_entry = '0;
      // stopped clock holds
      // Everything but the buffer ready register freezes while the controller has its clocks stopped.
      if (i_clk_run) begin
         rd_go  = !i_rd_sel_n && !st_reg.rd_last;
         wr_req = !i_wr_sel_n && !st_reg.wr_last;
         wr_go  = wr_req && !(!i_rd_sel_n && st_reg.prev_nop);
         st_next.rd_last  = rd_go;
         st_next.wr_last  = wr_go;
         st_next.prev_nop = i_rd_sel_n && i_wr_sel_n;

         st_next.rd_v0 = rd_go;
         st_next.rd_a0 = i_addr;
         st_next.rd_v1 = st_reg.rd_v0;
         st_next.rd_a1 = st_reg.rd_a0;
         st_next.rd_v2 = st_reg.rd_v1;
         st_next.rd_a2 = st_reg.rd_a1 + bds_pkg::BDS_ADDR_TWO;

         if (st_reg.rd_v1 || st_reg.rd_v2) begin
            st_next.q_rise  = rd_word0;
            st_next.q_fall  = rd_word1;
            st_next.q_oe    = 1'b1;
            st_next.q_valid = 1'b1;
         end else begin
            st_next.q_rise  = bds_pkg::BDS_DATA_IDLE;
            st_next.q_fall  = bds_pkg::BDS_DATA_IDLE;
            st_next.q_oe    = 1'b0;
            st_next.q_valid = 1'b0;
         end

         st_next.wr_v0 = wr_go;
         st_next.wr_a0 = i_addr;
         st_next.wr_v1 = st_reg.wr_v0;
         st_next.wr_a1 = st_reg.wr_a0 + bds_pkg::BDS_ADDR_TWO;

         push_valid = st_reg.wr_v0 || st_reg.wr_v1;
         push_entry.addr        = st_reg.wr_v0 ? st_reg.wr_a0 : st_reg.wr_a1;
         push_entry.data_rise   = i_wr_data_rise;
         push_entry.data_fall   = i_wr_data_fall;
         push_entry.mask_rise_n = {i_lane1_write_mask_n_rise, i_lane0_write_mask_n_rise};
         push_entry.mask_fall_n = {i_lane1_write_mask_n_fall, i_lane0_write_mask_n_fall};
      end
      st_next.wbuf_ready = fifo_in_ready;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_reg <= bds_pkg::BDS_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rd_data_rise = st_reg.q_rise;
   assign o_rd_data_fall = st_reg.q_fall;
   assign o_rd_oe        = st_reg.q_oe;
   assign o_rd_valid     = st_reg.q_valid;
   assign o_wbuf_ready   = st_reg.wbuf_ready;

   // --------------------------------------------------------------------
   // Write buffer and array write port
   // --------------------------------------------------------------------
   // Reads own the array while a burst is being driven, so the buffer drains
   // in the gaps; back-to-back reads let it fill, and a full buffer drops beats.
   assign wbuf_take  = i_clk_run && !(st_reg.rd_v1 || st_reg.rd_v2);
   assign wbuf_pop   = wbuf_valid && wbuf_take;
   assign wr_addr_hi = wbuf_out.addr + bds_pkg::BDS_ADDR_ONE;

   bds_fifo #(
      .WIDTH ($bits(bds_pkg::bds_wbeat_s)),
      .DEPTH (bds_pkg::BDS_WBUF_DEPTH)
   ) i_bds_fifo (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_in_valid  (push_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (push_entry),
      .o_out_valid (wbuf_valid),
      .i_out_ready (wbuf_take),
      .o_out_data  (wbuf_out)
   );

   always_ff @(posedge i_clk_sys) begin
      if (wbuf_pop) begin
         for (int l = 0; l < NL; l++) begin
            if (!wbuf_out.mask_rise_n[l]) begin
               mem[wbuf_out.addr][l*LW +: LW] <= wbuf_out.data_rise[l*LW +: LW];
            end
            if (!wbuf_out.mask_fall_n[l]) begin
               mem[wr_addr_hi][l*LW +: LW] <= wbuf_out.data_fall[l*LW +: LW];
            end
         end
      end
   end

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   sequence s_rd_taken;
      rd_go ##1 i_clk_run[*2];
   endsequence

   sequence s_wr_taken;
      wr_go ##1 i_clk_run;
   endsequence

   // A read with no second read two edges later, followed for its whole burst.
   sequence s_rd_lone;
      rd_go ##1 i_clk_run ##1 (i_clk_run && !rd_go) ##1 i_clk_run[*2];
   endsequence

   // A write with no second write two edges later, followed past its last beat pair.
   sequence s_wr_lone;
      wr_go ##1 i_clk_run ##1 (i_clk_run && !wr_go) ##1 i_clk_run;
   endsequence

   a_rd_latency_oe: assert property (s_rd_taken |=> o_rd_oe)
      else $error("read data not driven two cycles after read taken");

   a_rd_four_beats: assert property (s_rd_taken ##1 i_clk_run |=> o_rd_oe && $past(o_rd_oe))
      else $error("read burst shorter than four beats");

   a_rd_repeat_drop: assert property (rd_go ##1 i_clk_run |-> !rd_go)
      else $error("read on next edge after accepted read was taken");

   a_wr_repeat_drop: assert property (wr_go ##1 i_clk_run |-> !wr_go)
      else $error("write on next edge after accepted write was taken");

   a_nop_rd_wins: assert property ((i_clk_run && i_rd_sel_n && i_wr_sel_n)
      ##1 (i_clk_run && !i_rd_sel_n && !i_wr_sel_n) |-> rd_go && !wr_go)
      else $error("both selects after idle did not give read only");

   a_stop_hold: assert property (!i_clk_run |=> $stable(o_rd_data_rise)
      && $stable(o_rd_data_fall) && $stable(o_rd_oe))
      else $error("outputs changed while clock stopped");

   a_idle_release: assert property ((i_clk_run && !st_reg.rd_v1 && !st_reg.rd_v2)
      |=> !o_rd_oe && (o_rd_data_rise == '0))
      else $error("read outputs driven with no burst pending");

   a_wr_beat_push: assert property (s_wr_taken |-> (push_valid
      && (push_entry.addr == $past(i_addr))) ##1 (!i_clk_run || push_valid))
      else $error("write beats not captured on the two following edges");

   a_wr_addr_step: assert property (s_wr_taken ##1 i_clk_run |->
      push_entry.addr == $past(i_addr, 2) + bds_pkg::BDS_ADDR_TWO)
      else $error("second write beat pair not at start plus two");

   a_rd_addr_step: assert property (st_reg.rd_v2 && $past(i_clk_run) |->
      st_reg.rd_a2 == $past(st_reg.rd_a1) + bds_pkg::BDS_ADDR_TWO)
      else $error("second read beat pair not at start plus two");

   a_wbuf_ready_out: assert property (!fifo_in_ready |=> !o_wbuf_ready)
      else $error("buffer ready output shows room while buffer full");

   a_wbuf_ready_back: assert property (fifo_in_ready |=> o_wbuf_ready)
      else $error("buffer ready output low while buffer has room");

   // --------------------------------------------------------------------
   // Burst length, origin and clock stop checks
   // --------------------------------------------------------------------
   // The burst length checks follow the pins and the pipeline ends rather than single registers,
   // so a restructured sequencer is still held to the same cycle counts.
   // Stopped edges never count, which is why every step after rd_go or wr_go names the run level.

   a_rd_burst_end: assert property (s_rd_lone |=> !o_rd_oe)
      else $error("read burst longer than four beats");

   a_wr_two_pairs: assert property (s_wr_lone |-> !push_valid)
      else $error("write pushed more than two beat pairs");

   a_rd_addr_origin: assert property (s_rd_taken |-> st_reg.rd_a1 == $past(i_addr, 2))
      else $error("read burst does not start at the registered address");

   a_rd_addr_second: assert property (s_rd_taken ##1 i_clk_run |->
      st_reg.rd_a2 == $past(i_addr, 3) + bds_pkg::BDS_ADDR_TWO)
      else $error("second read pair not at registered address plus two");

   a_rd_start_oe: assert property ((i_clk_run && !i_rd_sel_n && !st_reg.rd_last)
      ##1 i_clk_run[*2] |=> o_rd_oe)
      else $error("read select low did not start a read burst");

   a_wr_start_push: assert property ((i_clk_run && !i_wr_sel_n && !st_reg.wr_last
      && (i_rd_sel_n || !st_reg.prev_nop)) ##1 i_clk_run |-> push_valid)
      else $error("write select low did not capture write beats");

   a_nop_no_beats: assert property ((i_clk_run && i_rd_sel_n && i_wr_sel_n)
      ##1 (i_clk_run && !i_rd_sel_n && !i_wr_sel_n) ##1 i_clk_run |-> !push_valid)
      else $error("write beats captured for a write dropped after idle");

   a_wr_beat_data: assert property (s_wr_taken |-> (push_entry.data_rise == i_wr_data_rise)
      && (push_entry.data_fall == i_wr_data_fall))
      else $error("first write beat pair not taken from the data inputs");

   a_wr_mask_lanes: assert property (s_wr_taken |->
      (push_entry.mask_rise_n == {i_lane1_write_mask_n_rise, i_lane0_write_mask_n_rise})
      && (push_entry.mask_fall_n == {i_lane1_write_mask_n_fall, i_lane0_write_mask_n_fall}))
      else $error("write masks not sampled with their beats");

   a_stop_no_push: assert property (!i_clk_run |-> !push_valid && !wbuf_pop
      && !rd_go && !wr_go)
      else $error("command or buffer activity while clock stopped");

   a_stop_seq_hold: assert property (!i_clk_run |=> $stable(st_reg.rd_v0)
      && $stable(st_reg.rd_v1) && $stable(st_reg.rd_v2)
      && $stable(st_reg.wr_v0) && $stable(st_reg.wr_v1))
      else $error("sequencer state moved while clock stopped");

   a_wbuf_held_reads: assert property ((st_reg.rd_v1 || st_reg.rd_v2) |-> !wbuf_pop)
      else $error("write buffer drained while a read pair was driven");

   a_rd_valid_copy: assert property (o_rd_valid == o_rd_oe)
      else $error("read valid differs from read output enable");

   a_rd_idle_zero: assert property (!o_rd_oe |-> (o_rd_data_rise == '0)
      && (o_rd_data_fall == '0))
      else $error("read data not at idle level while outputs released");

endmodule

`default_nettype wire

//--- verif/bds_ctrl_model.sv
// Behavioural memory controller that drives commands and write beats.
`timescale 1ns/100ps
`default_nettype none

module bds_ctrl_model #(
   parameter int AW = bds_pkg::BDS_ADDR_W,
   parameter int DW = bds_pkg::BDS_DATA_W
) (
   input  wire logic      i_clk_sys,
   output logic          o_clk_run,
   output logic          o_rd_sel_n,
   output logic          o_wr_sel_n,
   output logic [AW-1:0] o_addr,
   output logic [DW-1:0] o_data_rise,
   output logic [DW-1:0] o_data_fall,
   output logic [3:0]    o_mask_n
);
   logic [DW-1:0] wd [4];
   logic [1:0]    wm [4];
   logic [DW-1:0] pr [2];
   logic [DW-1:0] pf [2];
   logic [3:0]    pm [2];
   logic [1:0]    pv = '0;
   logic          prev_rd = 1'h0;
   logic          prev_wr = 1'h0;

   initial begin
      {o_clk_run, o_rd_sel_n, o_wr_sel_n, o_mask_n} = '1;
      {o_addr, o_data_rise, o_data_fall} = '0;
   end

   // ---------------------------------------------------------------
   // Drive tasks
   // ---------------------------------------------------------------
   // one command pair per rising edge
   task automatic drive(input logic rd, input logic wr, input logic [AW-1:0] a);
      @(posedge i_clk_sys);
      #1;
      {o_rd_sel_n, o_wr_sel_n, o_addr} = {~rd, ~wr, a};
      // beat pairs one and two cycles after the write edge
      if (pv[0]) begin
         {o_data_rise, o_data_fall, o_mask_n} = {pr[0], pf[0], pm[0]};
      end else begin
         // Released lines toggle so a stale beat is never mistaken for data.
         {o_data_rise, o_data_fall, o_mask_n} = ~{o_data_rise, o_data_fall, o_mask_n};
      end
      {pr[0], pf[0], pm[0], pv} = {pr[1], pf[1], pm[1], 1'h0, pv[1]};
      if (wr) begin
         {pr[0], pf[0], pm[0]} = {wd[0], wd[1], wm[1], wm[0]};
         {pr[1], pf[1], pm[1]} = {wd[2], wd[3], wm[3], wm[2]};
         pv = 2'h3;
      end
      {prev_rd, prev_wr} = {rd, wr};
   endtask

   // same-type spacing, broken only when forced
   task automatic step(input logic rd, input logic wr, input logic [AW-1:0] a,
                       input logic force_cmd);
      if (!force_cmd && ((rd && prev_rd) || (wr && prev_wr))) begin
         drive(1'h0, 1'h0, o_addr);
      end
      drive(rd, wr, a);
   endtask

   // clocks are stopped with read select held low
   task automatic halt(input int n);
      @(posedge i_clk_sys);
      #1;
      {o_clk_run, o_rd_sel_n} = 2'h0;
      repeat (n) @(posedge i_clk_sys);
      #1;
      {o_clk_run, o_rd_sel_n, prev_rd} = 3'h6;
   endtask
endmodule
`default_nettype wire

//--- verif/bds_sram_bench.sv
// Self-checking bench for the burst-of-four DDR SRAM command timing block.
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module bds_sram_bench;
   localparam int AW = bds_pkg::BDS_ADDR_W;
   localparam int DW = bds_pkg::BDS_DATA_W;
   logic          clk_sys = 1'h0;
   logic          rst = 1'h1;
   logic          clk_run, rd_sel_n, wr_sel_n, rd_oe, rd_valid, wbuf_ready;
   logic [AW-1:0] addr;
   logic [DW-1:0] wd_rise, wd_fall, rd_rise, rd_fall;
   logic [3:0]    mask_n;
   logic [DW-1:0] exp_mem [logic [AW-1:0]];
   int            errors = 0;
   int            comparisons = 0;

   always #2.5 clk_sys = ~clk_sys;

   bds_ctrl_model i_bds_ctrl_model (.i_clk_sys(clk_sys), .o_clk_run(clk_run),
      .o_rd_sel_n(rd_sel_n), .o_wr_sel_n(wr_sel_n), .o_addr(addr),
      .o_data_rise(wd_rise), .o_data_fall(wd_fall), .o_mask_n(mask_n));

   bds_sram i_bds_sram (.i_clk_sys(clk_sys), .i_rst(rst), .i_clk_run(clk_run),
      .i_rd_sel_n(rd_sel_n), .i_wr_sel_n(wr_sel_n), .i_addr(addr),
      .i_wr_data_rise(wd_rise), .i_wr_data_fall(wd_fall),
      .i_lane0_write_mask_n_rise(mask_n[0]), .i_lane1_write_mask_n_rise(mask_n[1]),
      .i_lane0_write_mask_n_fall(mask_n[2]), .i_lane1_write_mask_n_fall(mask_n[3]),
      .o_rd_data_rise(rd_rise), .o_rd_data_fall(rd_fall), .o_rd_oe(rd_oe),
      .o_rd_valid(rd_valid), .o_wbuf_ready(wbuf_ready));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic idle(input int n);
      repeat (n) i_bds_ctrl_model.step(1'h0, 1'h0, '0, 1'h0);
   endtask

   task automatic stage(input logic [DW-1:0] seed, input logic [7:0] masks);
      for (int k = 0; k < 4; k++) begin
         i_bds_ctrl_model.wd[k] = seed + DW'(k);
         i_bds_ctrl_model.wm[k] = masks[2*k+:2];
      end
   endtask

   // A masked lane keeps the old content, so expectations merge per lane.
   task automatic commit(input logic [AW-1:0] a);
      for (int k = 0; k < 4; k++) begin
         if (!i_bds_ctrl_model.wm[k][0]) exp_mem[a+AW'(k)][8:0] = i_bds_ctrl_model.wd[k][8:0];
         if (!i_bds_ctrl_model.wm[k][1]) exp_mem[a+AW'(k)][17:9] = i_bds_ctrl_model.wd[k][17:9];
      end
   endtask

   task automatic wr(input logic [AW-1:0] a);
      i_bds_ctrl_model.step(1'h0, 1'h1, a, 1'h0);
      commit(a);
      idle(40);
   endtask

   task automatic rd_check(input logic [AW-1:0] a, input logic both, input logic dup,
                           input logic wnext, input logic [AW-1:0] b);
      i_bds_ctrl_model.step(1'h1, both, a, 1'h0);
      i_bds_ctrl_model.step(dup, wnext, b, 1'h1);
      if (wnext) commit(b);
      idle(2);
      for (int k = 0; k < 2; k++) begin
         `CHK(rd_oe, 1'h1)
         `CHK(rd_valid, 1'h1)
         `CHK(rd_rise, exp_mem[a+AW'(2*k)])
         `CHK(rd_fall, exp_mem[a+AW'(2*k+1)])
         idle(1);
      end
      `CHK(rd_oe, 1'h0)
      `CHK(rd_rise, '0)
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_walk;
      stage(18'h3A5C1, 8'h00);
      wr(20'hFFFFE);
      rd_check(20'hFFFFE, 1'h0, 1'h0, 1'h0, '0);
   endtask

   task automatic t_mask;
      stage(18'h3FFFF, 8'h00);
      wr(20'h00100);
      stage(18'h00000, 8'hC6);
      wr(20'h00100);
      rd_check(20'h00100, 1'h0, 1'h0, 1'h0, '0);
   endtask

   task automatic t_refuse;
      rd_check(20'h00100, 1'h0, 1'h1, 1'h0, 20'hFFFFE);
      stage(18'h2AAAA, 8'h00);
      rd_check(20'h00100, 1'h1, 1'h0, 1'h0, '0);
      idle(40);
      rd_check(20'h00100, 1'h0, 1'h0, 1'h0, '0);
   endtask

   task automatic t_wr_dup;
      stage(18'h0F0F0, 8'h00);
      wr(20'h00400);
      stage(18'h30303, 8'h00);
      i_bds_ctrl_model.step(1'h0, 1'h1, 20'h00300, 1'h0);
      i_bds_ctrl_model.step(1'h0, 1'h1, 20'h00400, 1'h1);
      idle(40);
      rd_check(20'h00400, 1'h0, 1'h0, 1'h0, '0);
   endtask

   task automatic t_overlap;
      stage(18'h15555, 8'h00);
      rd_check(20'hFFFFE, 1'h0, 1'h0, 1'h1, 20'h00200);
      idle(40);
      rd_check(20'h00200, 1'h0, 1'h0, 1'h0, '0);
   endtask

   // Streaming reads block the drain, so alternating writes must fill the buffer.
   task automatic t_fill;
      logic full;
      full = 1'h0;
      for (int k = 0; k < 20; k++) begin
         i_bds_ctrl_model.step(1'h1, 1'h0, 20'h40000, 1'h0);
         i_bds_ctrl_model.step(1'h0, 1'h1, 20'h40000 + AW'(4 * k), 1'h0);
         if (wbuf_ready === 1'h0) full = 1'h1;
      end
      `CHK(full, 1'h1)
      idle(60);
      `CHK(wbuf_ready, 1'h1)
   endtask

   task automatic t_stop;
      i_bds_ctrl_model.halt(4);
      for (int k = 0; k < 4; k++) begin
         idle(1);
         `CHK(rd_oe, 1'h0)
      end
   endtask

   task automatic end_sim;
      if (errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #100000;
      errors++;
      end_sim;
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'h0;
      idle(2);
      `CHK(rd_oe, 1'h0)
      `CHK(wbuf_ready, 1'h1)
      t_walk;
      t_mask;
      t_refuse;
      t_wr_dup;
      t_overlap;
      t_fill;
      t_stop;
      end_sim;
   end
endmodule
`default_nettype wire
